// ===== irlrs_map.vh
// Constants for the level-request sampling block.
// Assumes a single 10 MHz core-side clock; other clock periods are given in ns.
`ifndef IRLRS_MAP_VH
`define IRLRS_MAP_VH

// ----------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------
`define IRLRS_MCLK_NS 100
`define IRLRS_ICYC_NS 100
`define IRLRS_ECYC_NS 100
`define IRLRS_PCYC_NS 100

// ----------------------------------------------------------------
// Widths and codes
// ----------------------------------------------------------------
`define IRLRS_LVL_W 4
`define IRLRS_VEC_W 8
`define IRLRS_ADDR_W 32
`define IRLRS_LVL_NONE 4'h0
`define IRLRS_VEC_RESET 8'h00

// ----------------------------------------------------------------
// Peripheral request path: 0.5 Icyc + 1.0 Pcyc, rounded up to mclk cycles
// ----------------------------------------------------------------
`define IRLRS_PERIPH_NS ((`IRLRS_ICYC_NS / 2) + `IRLRS_PCYC_NS)
`define IRLRS_PERIPH_CYC ((`IRLRS_PERIPH_NS + `IRLRS_MCLK_NS - 1) / `IRLRS_MCLK_NS)

`endif

// ===== irlrs_noise_filter.v
// Noise canceler for the encoded level-request code.
// Assumes its input is already synchronised to i_mclk and the tick is a one-cycle strobe.
`timescale 1ns/1ps

module irlrs_noise_filter #(
	parameter W = 4
) (
	input wire i_mclk,
	input wire i_sys_rst,
	input wire i_clk_en,
	input wire i_tick,
	input wire [W-1:0] i_code,
	output reg [W-1:0] o_code
);

reg [W-1:0] last_sample;

// ----------------------------------------------------------------
// Two-sample agreement
// ----------------------------------------------------------------
// A glitch shorter than one tick spacing never reaches the output
always @(posedge i_mclk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		last_sample <= {W{1'b0}};
		o_code <= {W{1'b0}};
	end
	else if (i_clk_en && i_tick)
	begin
		last_sample <= i_code;
		if (i_code == last_sample)
			o_code <= i_code;
	end
end

endmodule

// ===== irlrs_request_sampling.v
// Level-request sampling, peripheral request delay, priority accept and
// external vector fetch, plus a one-entry store buffer with load ordering.
// Assumes all i_ signals except the request pins are on i_mclk.
`timescale 1ns/1ps
`include "irlrs_map.vh"

module irlrs_request_sampling #(
	parameter LVL_W = `IRLRS_LVL_W,
	parameter VEC_W = `IRLRS_VEC_W,
	parameter ADDR_W = `IRLRS_ADDR_W,
	parameter PERIPH_CYC = `IRLRS_PERIPH_CYC
) (
	input wire i_mclk,
	input wire i_sys_rst,
	input wire i_clk_en,
	input wire i_pclk_tick,
	input wire [LVL_W-1:0] i_level_request_pins_n,
	input wire i_periph_req,
	input wire [LVL_W-1:0] i_periph_level,
	input wire [VEC_W-1:0] i_periph_vector,
	input wire [LVL_W-1:0] i_interrupt_mask_level,
	input wire i_cpu_sample,
	input wire i_ext_vector_mode,
	input wire [VEC_W-1:0] i_vector_number_lines,
	input wire i_store_valid,
	input wire [ADDR_W-1:0] i_store_addr,
	input wire i_store_done,
	input wire i_load_valid,
	input wire [ADDR_W-1:0] i_load_addr,
	output reg o_irq_req,
	output reg [LVL_W-1:0] o_irq_level,
	output reg o_accept,
	output reg [LVL_W-1:0] o_accepted_level,
	output reg o_vector_fetch,
	output reg o_vector_valid,
	output reg [VEC_W-1:0] o_vector_number,
	output reg o_periph_visible,
	output reg o_store_busy,
	output reg o_load_done
);

// ----------------------------------------------------------------
// Pin synchroniser
// ----------------------------------------------------------------
reg [LVL_W-1:0] pin_meta;
reg [LVL_W-1:0] pin_sync;
wire [LVL_W-1:0] ext_level;

always @(posedge i_mclk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		pin_meta <= {LVL_W{1'b1}};
		pin_sync <= {LVL_W{1'b1}};
	end
	else if (i_clk_en)
	begin
		pin_meta <= i_level_request_pins_n;
		pin_sync <= pin_meta;
	end
end

// Pins are active low: all high means no request
irlrs_noise_filter #(
	.W(LVL_W)
) u_filter (
	.i_mclk(i_mclk),
	.i_sys_rst(i_sys_rst),
	.i_clk_en(i_clk_en),
	.i_tick(i_pclk_tick),
	.i_code(~pin_sync),
	.o_code(ext_level)
);

// ----------------------------------------------------------------
// Peripheral request delay line
// ----------------------------------------------------------------
// Same delay for rise and fall, so the CPU sees withdrawal as late as arrival
reg [PERIPH_CYC-1:0] periph_pipe;
wire [PERIPH_CYC:0] periph_chain;

assign periph_chain[0] = i_periph_req;

genvar g;
generate
	for (g = 0; g < PERIPH_CYC; g = g + 1)
	begin : g_pdly
		always @(posedge i_mclk or posedge i_sys_rst)
		begin
			if (i_sys_rst)
				periph_pipe[g] <= 1'b0;
			else if (i_clk_en)
				periph_pipe[g] <= periph_chain[g];
		end
		assign periph_chain[g+1] = periph_pipe[g];
	end
endgenerate

wire periph_seen;
assign periph_seen = periph_chain[PERIPH_CYC];

// ----------------------------------------------------------------
// Priority select and mask compare
// ----------------------------------------------------------------
reg [LVL_W-1:0] next_level;
reg next_from_periph;
reg next_req;

always @*
begin
	next_level = ext_level;
	next_from_periph = 1'b0;
	// Equal priority goes to the pins; pin encoding has no source index
	if (periph_seen && (i_periph_level > ext_level))
	begin
		next_level = i_periph_level;
		next_from_periph = 1'b1;
	end
	next_req = (next_level > i_interrupt_mask_level);
end

reg sel_periph;

always @(posedge i_mclk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		o_irq_req <= 1'b0;
		o_irq_level <= `IRLRS_LVL_NONE;
		sel_periph <= 1'b0;
		o_periph_visible <= 1'b0;
	end
	else if (i_clk_en)
	begin
		o_irq_req <= next_req;
		o_irq_level <= next_level;
		sel_periph <= next_from_periph;
		o_periph_visible <= periph_seen;
	end
end

// ----------------------------------------------------------------
// Acceptance and vector sequencer
// ----------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_VFETCH = 2'h1;
localparam ST_VCAPT = 2'h2;

reg [1:0] state;
reg [1:0] next_state;

always @*
begin
	next_state = state;
	case (state)
		ST_IDLE:
			if (i_cpu_sample && o_irq_req && !sel_periph && i_ext_vector_mode)
				next_state = ST_VFETCH;
		ST_VFETCH:
			next_state = ST_VCAPT;
		ST_VCAPT:
			next_state = ST_IDLE;
		default:
			next_state = ST_IDLE;
	endcase
end

// Sampling only in IDLE stops a second accept while a vector is in flight
wire take;
assign take = (state == ST_IDLE) && i_cpu_sample && o_irq_req;

always @(posedge i_mclk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		state <= ST_IDLE;
		o_accept <= 1'b0;
		o_accepted_level <= `IRLRS_LVL_NONE;
		o_vector_fetch <= 1'b0;
		o_vector_valid <= 1'b0;
		o_vector_number <= `IRLRS_VEC_RESET;
	end
	else if (i_clk_en)
	begin
		state <= next_state;
		o_accept <= take;
		o_vector_valid <= 1'b0;
		o_vector_fetch <= (next_state == ST_VFETCH);
		if (take)
			o_accepted_level <= o_irq_level;
		if (take && (sel_periph || !i_ext_vector_mode))
		begin
			o_vector_number <= sel_periph ? i_periph_vector : {{(VEC_W-LVL_W){1'b0}}, o_irq_level};
			o_vector_valid <= 1'b1;
		end
		if (state == ST_VFETCH)
		begin
			o_vector_number <= i_vector_number_lines;
			o_vector_valid <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------
// One-entry store buffer and load ordering
// ----------------------------------------------------------------
// One entry only: a second store waits on o_store_busy from the issuer
reg [ADDR_W-1:0] store_addr;
wire load_conflict;
assign load_conflict = o_store_busy && (store_addr == i_load_addr);

always @(posedge i_mclk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		o_store_busy <= 1'b0;
		store_addr <= {ADDR_W{1'b0}};
		o_load_done <= 1'b0;
	end
	else if (i_clk_en)
	begin
		if (i_store_valid && !o_store_busy)
		begin
			o_store_busy <= 1'b1;
			store_addr <= i_store_addr;
		end
		else if (i_store_done)
			o_store_busy <= 1'b0;
		o_load_done <= i_load_valid && !load_conflict && !o_load_done;
	end
end

endmodule

// ===== irlrs_ext_src.sv
// Far-side model: external level source and vector driver.
// Assumes the bench sets i_level with i_go just after a clock edge.
`timescale 1ns/1ps
module irlrs_ext_src (
	input wire i_mclk,
	input wire i_go,
	input wire i_fetch,
	input wire [3:0] i_level,
	input wire [7:0] i_vector,
	output reg [3:0] o_pins_n,
	output wire [7:0] o_lines
);
	reg [7:0] noise;
	initial o_pins_n = 4'hf;
	initial noise = 8'h5a;
	// Undriven vector lines toggle so stale data never matches
	assign o_lines = i_fetch ? i_vector : noise;
	always @(posedge i_mclk)
	begin
		noise <= #1 ~noise;
		if (i_go)
			o_pins_n <= #1 ~i_level;
		else if (i_fetch)
			o_pins_n <= #1 4'hf;
	end
endmodule

// ===== irlrs_chk.sv
// Port checker for irlrs_request_sampling.
// Assumes i_clk_en is held high throughout and the filter tick comes every other cycle.
`timescale 1ns/1ps
module irlrs_chk #(
	parameter PERIPH_CYC = 2
) (
	input wire i_mclk,
	input wire i_sys_rst,
	input wire i_periph_req,
	input wire [3:0] i_interrupt_mask_level,
	input wire [3:0] i_level_request_pins_n,
	input wire [7:0] i_vector_number_lines,
	input wire [31:0] i_store_addr,
	input wire [31:0] i_load_addr,
	input wire o_periph_visible,
	input wire [3:0] o_irq_level,
	input wire o_accept,
	input wire [3:0] o_accepted_level,
	input wire o_vector_fetch,
	input wire o_vector_valid,
	input wire [7:0] o_vector_number,
	input wire o_store_busy,
	input wire o_load_done
);
	localparam int D = PERIPH_CYC + 1;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	sequence s_vec;
		o_vector_valid && o_vector_number == $past(i_vector_number_lines);
	endsequence
	vis_rise_a: assert property ($rose(i_periph_req) |-> ##D o_periph_visible)
		else $error("peripheral request seen late");
	vis_fall_a: assert property ($fell(i_periph_req) |-> ##D !o_periph_visible)
		else $error("peripheral withdrawal seen late");
	accept_gt_a: assert property (o_accept |-> o_accepted_level > $past(i_interrupt_mask_level))
		else $error("accepted level not above mask");
	fetch_accept_a: assert property (o_vector_fetch |-> o_accept)
		else $error("vector fetch without accept");
	vec_capture_a: assert property (o_vector_fetch |=> s_vec)
		else $error("vector not taken from lines");
	// Filter compares pin codes one tick apart: 4 and 6 edges before the level moves
	filter_stable_a: assert property ($changed(o_irq_level) && !o_periph_visible
		&& !$past(o_periph_visible)
		|-> $past(i_level_request_pins_n, 4) == $past(i_level_request_pins_n, 6))
		else $error("level changed on unsettled pins");
	load_order_a: assert property (o_load_done |-> !$past(o_store_busy)
		|| $past(i_store_addr) != $past(i_load_addr))
		else $error("load passed pending store");
	load_pulse_a: assert property (o_load_done |=> !o_load_done)
		else $error("load done twice");
endmodule
bind irlrs_request_sampling irlrs_chk #(
	.PERIPH_CYC(PERIPH_CYC)
) u_chk (
	.i_mclk(i_mclk),
	.i_sys_rst(i_sys_rst),
	.i_periph_req(i_periph_req),
	.i_interrupt_mask_level(i_interrupt_mask_level),
	.i_level_request_pins_n(i_level_request_pins_n),
	.i_vector_number_lines(i_vector_number_lines),
	.i_store_addr(i_store_addr),
	.i_load_addr(i_load_addr),
	.o_periph_visible(o_periph_visible),
	.o_irq_level(o_irq_level),
	.o_accept(o_accept),
	.o_accepted_level(o_accepted_level),
	.o_vector_fetch(o_vector_fetch),
	.o_vector_valid(o_vector_valid),
	.o_vector_number(o_vector_number),
	.o_store_busy(o_store_busy),
	.o_load_done(o_load_done)
);

// ===== tb.sv
// Self-checking bench for irlrs_request_sampling.
// Assumes the external source model and the bound checker.
`timescale 1ns/1ps
module tb;
	localparam PC = 2;
	logic clk = 0, rst = 1, tick = 0, go = 0, sample = 0, ext = 0, preq = 0;
	logic sv = 0, sd = 0, lv = 0;
	logic [3:0] lvl = 0, mask = 0, plvl = 0;
	logic [7:0] pvec = 0, evec = 0;
	logic [31:0] saddr = 0, laddr = 0;
	wire [3:0] pins_n, ilvl, alvl;
	wire [7:0] lines, vnum;
	wire irq, acc, vf, vvd, pvis, sbusy, ldone;
	integer mismatches = 0, compares = 0, n;
	always #50 clk = ~clk;
	always @(posedge clk) tick <= #1 ~tick;
	irlrs_request_sampling #(.PERIPH_CYC(PC)) u_dut (.i_mclk(clk), .i_sys_rst(rst),
		.i_clk_en(1'b1), .i_pclk_tick(tick), .i_level_request_pins_n(pins_n),
		.i_periph_req(preq), .i_periph_level(plvl), .i_periph_vector(pvec),
		.i_interrupt_mask_level(mask), .i_cpu_sample(sample), .i_ext_vector_mode(ext),
		.i_vector_number_lines(lines), .i_store_valid(sv), .i_store_addr(saddr),
		.i_store_done(sd), .i_load_valid(lv), .i_load_addr(laddr), .o_irq_req(irq),
		.o_irq_level(ilvl), .o_accept(acc), .o_accepted_level(alvl),
		.o_vector_fetch(vf), .o_vector_valid(vvd), .o_vector_number(vnum),
		.o_periph_visible(pvis), .o_store_busy(sbusy), .o_load_done(ldone));
	irlrs_ext_src u_src (.i_mclk(clk), .i_go(go), .i_fetch(vf), .i_level(lvl),
		.i_vector(evec), .o_pins_n(pins_n), .o_lines(lines));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic do_rst;
		rst = 1;
		step(2);
		rst = 0;
	endtask
	// ----
	// Pin path: glitch, pending, accept, external vector
	// ----
	task automatic t_pins;
		ext = 1; mask = 4'h5; evec = 8'h3c; lvl = 4'h9; go = 1;
		step(1);
		lvl = 4'h0;
		step(1);
		go = 0;
		step(10);
		chk("irq_glitch", irq, 1'b0);
		lvl = 4'h5; go = 1;
		step(1);
		go = 0;
		step(10);
		chk("irq_pend", irq, 1'b0);
		chk("irq_level", ilvl, 4'h5);
		mask = 4'h4; sample = 1;
		for (n = 0; acc !== 1'b1 && n < 20; n++) step(1);
		sample = 0;
		chk("acc", acc, 1'b1);
		chk("acc_level", alvl, 4'h5);
		chk("fetch", vf, 1'b1);
		step(1);
		chk("vec_valid", vvd, 1'b1);
		chk("vec_num", vnum, 8'h3c);
		step(10);
		chk("irq_drop", irq, 1'b0);
	endtask
	// ----
	// Pin request in internal vector mode
	// ----
	task automatic t_pin_int;
		ext = 0; mask = 4'h0; lvl = 4'h7; go = 1;
		step(1);
		go = 0;
		for (n = 0; irq !== 1'b1 && n < 20; n++) step(1);
		chk("int_level", ilvl, 4'h7);
		sample = 1;
		for (n = 0; acc !== 1'b1 && n < 20; n++) step(1);
		sample = 0;
		chk("int_fetch", vf, 1'b0);
		chk("int_valid", vvd, 1'b1);
		chk("int_vec", vnum, 8'h07);
		lvl = 4'h0; go = 1;
		step(1);
		go = 0;
		step(10);
		chk("int_drop", irq, 1'b0);
	endtask
	// ----
	// Peripheral path delays and internal vector
	// ----
	task automatic t_periph;
		ext = 0; mask = 4'h0; plvl = 4'h3; pvec = 8'ha5; preq = 1;
		for (n = 0; pvis !== 1'b1 && n < 20; n++) step(1);
		chk("vis_rise", n, PC + 1);
		sample = 1;
		for (n = 0; acc !== 1'b1 && n < 20; n++) step(1);
		sample = 0;
		chk("p_valid", vvd, 1'b1);
		chk("p_vec", vnum, 8'ha5);
		preq = 0;
		for (n = 0; pvis !== 1'b0 && n < 20; n++) step(1);
		chk("vis_fall", n, PC + 1);
	endtask
	// Same-address load must wait behind the buffered store
	task automatic t_store;
		saddr = 32'h10; sv = 1;
		step(1);
		sv = 0; laddr = 32'h10; lv = 1;
		chk("busy", sbusy, 1'b1);
		step(3);
		chk("ld_wait", ldone, 1'b0);
		sd = 1;
		step(1);
		sd = 0;
		for (n = 0; ldone !== 1'b1 && n < 20; n++) step(1);
		lv = 0;
		chk("ld_done", ldone, 1'b1);
		chk("busy_clr", sbusy, 1'b0);
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		do_rst;
		t_pins;
		t_pin_int;
		t_periph;
		do_rst;
		t_store;
		report_and_stop;
	end
	// Whole run needs well under 200 cycles
	initial
	begin
		#300000;
		mismatches++;
		report_and_stop;
	end
endmodule
